//--- hdl/qcp_defs.svh
`ifndef QCP_DEFS_SVH
`define QCP_DEFS_SVH

// ----------------------------------------
// Register offsets on the plain port.
// ----------------------------------------
`define QCP_ADDR_W 3
`define QCP_OFS_COUNT_A 3'h0
`define QCP_OFS_COUNT_B 3'h1
`define QCP_OFS_COUNT_C 3'h2
`define QCP_OFS_COUNT_D 3'h3
`define QCP_OFS_CLK_SEL 3'h4
`define QCP_OFS_CONFIG1 3'h5
`define QCP_OFS_CONFIG2 3'h6
`define QCP_OFS_RUN 3'h7

// ----------------------------------------
// Field positions.
// ----------------------------------------
`define QCP_CFG1_PWM0 0
`define QCP_CFG1_CHAIN_LOW 2
`define QCP_CFG1_DIR_BASE 4
`define QCP_CFG2_PWM0_SIZE_LSB 0
`define QCP_CFG2_CAP_FUNC_LSB 4
`define QCP_RUN_HALVE_BASE 4

// ----------------------------------------
// Clock source codes and reset values.
// ----------------------------------------
`define QCP_CKSEL_PIN 2'h0
`define QCP_CKSEL_RC 2'h1
`define QCP_CKSEL_SLOW 2'h2
`define QCP_CKSEL_P128 2'h3
`define QCP_RESET_BYTE 8'h00

// ----------------------------------------
// Resolution masks of a single counter byte and of a chained PWM.
// ----------------------------------------
`define QCP_MASK_8 16'h00ff
`define QCP_MASK_10 16'h03ff
`define QCP_MASK_12 16'h0fff
`define QCP_MASK_14 16'h3fff
`define QCP_MASK_16 16'hffff

`endif

//--- hdl/qcp_pkg.sv
package qcp_pkg;

  typedef struct packed {
    logic [3:0][7:0] count;
    logic [3:0][7:0] compare;
    logic [1:0][7:0] shadow;
    logic [7:0] clk_sel;
    logic [7:0] config1;
    logic [7:0] config2;
    logic [7:0] run;
    logic [1:0] pwm_q;
    logic [3:0] irq;
    logic cap_prev;
    logic [7:0] rdata;
  } qcp_state_t;

  typedef struct packed {
    logic [3:0] src_prev;
    logic [3:0] halve_tog;
    logic [3:0] tick;
  } qcp_tick_state_t;

endpackage

//--- hdl/qcp_tick_if.sv
`timescale 1ns/100ps
`default_nettype none

interface qcp_tick_if;
  logic [7:0] clk_sel;
  logic [3:0] halve;
  logic [3:0] run;
  logic [3:0] tick;

  modport src (
    input clk_sel,
    input halve,
    input run,
    output tick
  );

  modport use_side (
    output clk_sel,
    output halve,
    output run,
    input tick
  );
endinterface

`default_nettype wire

//--- hdl/qcp_clock_tick.sv
`timescale 1ns/100ps
`default_nettype none

`include "qcp_defs.svh"

module qcp_clock_tick
  import qcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] pin_clk,
  input wire logic rc_clk,
  input wire logic rc_div4_clk,
  input wire logic clk_32k,
  input wire logic clk_1k,
  input wire logic clk_128,
  qcp_tick_if.src tk
);

  qcp_tick_state_t s;
  qcp_tick_state_t next_s;
  logic [3:0] src;

  // ----------------------------------------
  // Source selection per counter.
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_src
      always_comb begin
        case (tk.clk_sel[2*i +: 2])
          `QCP_CKSEL_PIN: src[i] = pin_clk[i];
          `QCP_CKSEL_RC: src[i] = (i < 2) ? rc_clk : clk_32k;
          `QCP_CKSEL_SLOW: src[i] = (i < 2) ? rc_div4_clk : clk_1k;
          default: src[i] = clk_128;
        endcase
      end
    end
  endgenerate

  // ----------------------------------------
  // Edge detection and optional halving.
  // ----------------------------------------
  always_comb begin
    next_s = s;
    for (int k = 0; k < 4; k++) begin
      next_s.src_prev[k] = src[k];
      next_s.tick[k] = 1'b0;
      // A stopped counter sees no edge at all, so the halver also freezes.
      if (tk.run[k] && src[k] && !s.src_prev[k]) begin
        if (tk.halve[k] && tk.clk_sel[2*k +: 2] == `QCP_CKSEL_PIN) begin
          next_s.halve_tog[k] = ~s.halve_tog[k];
          next_s.tick[k] = s.halve_tog[k];
        end else begin
          next_s.tick[k] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tk.tick = s.tick;

endmodule

`default_nettype wire

//--- hdl/qcp_counters.sv
// Overview of operation
// - Counters count only while run bit set; A and C run bits govern chained B, D.
// - Each counter has one byte location: read count or capture, write comparison.
// - Counts are readable at any time, correct on internal clocks.
// - A stopped counter holds its count and ignores external pin edges.
// - Counter-mode write sets comparison; up clears count, down loads written value.
// - Count change from a write takes effect on the next REF_CLK edge, without waiting for a counter edge.
// - PWM or capture writes leave count alone; entering counter mode changes nothing.
// - Two-bit clock select per counter; code zero picks its own port A pin.
// - Each counter can halve its external pin clock via its own bit.
// - Plain and PWM counting, captured or not, both directions; captured plain on A,B.
// - Chained pairs use A and C as low byte, B and D as high byte.
// - Pair A/B plain: separate counters, or chained 16-bit with A direction and irq.
// - PWM0 drives port B bit 0; A loses irq; chained PWM has no irqs.
// - Nonzero capture function captures A and B; irqs come from capture events.
// - Pair C/D chains and drives PWM1 on port B bit 1, without capture.
// - Irq A, B, C, D route by default to high 4, low 5, high 3, low 4.
// - Direction bit zero counts down, one counts up.
// - On target (up) or zero (down) the next counter clock raises irq and reloads at once.
// - PWM internal signal high while count is at most the code; output registered.
`timescale 1ns/100ps
`default_nettype none

`include "qcp_defs.svh"

module qcp_counters
  import qcp_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RD_DATA,
  input wire logic [3:0] PIN_CLK,
  input wire logic RC_EXT_CLK,
  input wire logic RC_EXT_DIV4_CLK,
  input wire logic CLK_32K,
  input wire logic CLK_1K,
  input wire logic CLK_128,
  input wire logic CAPTURE_SIG,
  output logic IRQ_A,
  output logic IRQ_B,
  output logic IRQ_C,
  output logic IRQ_D,
  output logic PWM_OUT0,
  output logic PWM_OUT1,
  output logic PWM_OE0,
  output logic PWM_OE1
);

  qcp_state_t s;
  qcp_state_t next_s;
  qcp_tick_if tk ();

  // ----------------------------------------
  // Helper functions.
  // ----------------------------------------

  // One counter step; bit 16 flags a terminal hit in counter mode.
  function automatic logic [16:0] step_count(
    input logic [15:0] value,
    input logic [15:0] target,
    input logic [15:0] mask,
    input logic up,
    input logic counter_mode
  );
    logic [15:0] res;
    logic hit;
    res = 16'h0000;
    hit = 1'b0;
    if (counter_mode) begin
      if (up) begin
        hit = (value == target);
        res = hit ? 16'h0000 : 16'(value + 16'h0001);
      end else begin
        hit = (value == 16'h0000);
        res = hit ? target : 16'(value - 16'h0001);
      end
    end else begin
      // PWM and captured counting simply wrap inside the mask.
      res = 16'(up ? value + 16'h0001 : value - 16'h0001) & mask;
    end
    return {hit, res};
  endfunction

  function automatic logic [15:0] res_mask(input logic [1:0] size);
    case (size)
      2'h0: return `QCP_MASK_10;
      2'h1: return `QCP_MASK_12;
      2'h2: return `QCP_MASK_14;
      default: return `QCP_MASK_16;
    endcase
  endfunction

  // ----------------------------------------
  // Clock tick generation.
  // ----------------------------------------
  assign tk.clk_sel = s.clk_sel;
  assign tk.halve = s.run[7:4];
  assign tk.run = s.run[3:0];

  qcp_clock_tick u_tick (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .pin_clk(PIN_CLK),
    .rc_clk(RC_EXT_CLK),
    .rc_div4_clk(RC_EXT_DIV4_CLK),
    .clk_32k(CLK_32K),
    .clk_1k(CLK_1K),
    .clk_128(CLK_128),
    .tk(tk.src)
  );

  // ----------------------------------------
  // Next state.
  // ----------------------------------------
  logic capture_on;
  logic cap_event;

  always_comb begin
    logic chain;
    logic pwm;
    logic cap;
    logic up_l;
    logic up_h;
    logic wr_mode;
    logic [15:0] mask;
    logic [16:0] r16;
    logic [16:0] r8;
    int l;
    int h;
    chain = 1'b0;
    pwm = 1'b0;
    cap = 1'b0;
    up_l = 1'b0;
    up_h = 1'b0;
    wr_mode = 1'b0;
    mask = `QCP_MASK_8;
    r16 = 17'h00000;
    r8 = 17'h00000;
    l = 0;
    h = 1;
    next_s = s;
    next_s.irq = 4'h0;
    next_s.rdata = 8'h00;
    next_s.cap_prev = CAPTURE_SIG;
    capture_on = (s.config2[`QCP_CFG2_CAP_FUNC_LSB +: 2] != 2'h0);
    cap_event = (s.config2[`QCP_CFG2_CAP_FUNC_LSB] && CAPTURE_SIG && !s.cap_prev) ||
      (s.config2[`QCP_CFG2_CAP_FUNC_LSB + 1] && !CAPTURE_SIG && s.cap_prev);

    // Counting, one pair at a time.
    for (int p = 0; p < 2; p++) begin
      l = 2 * p;
      h = 2 * p + 1;
      chain = s.config1[`QCP_CFG1_CHAIN_LOW + p];
      pwm = s.config1[`QCP_CFG1_PWM0 + p];
      cap = (p == 0) && capture_on;
      up_l = s.config1[`QCP_CFG1_DIR_BASE + l];
      up_h = s.config1[`QCP_CFG1_DIR_BASE + h];
      if (chain) begin
        // Only the low counter's run bit and clock drive the chained pair.
        if (tk.tick[l]) begin
          mask = pwm ? res_mask(s.config2[2*p +: 2]) : `QCP_MASK_16;
          r16 = step_count({s.count[h], s.count[l]}, {s.compare[h], s.compare[l]},
            mask, up_l, !pwm && !cap);
          next_s.count[l] = r16[7:0];
          next_s.count[h] = r16[15:8];
          if (pwm) begin
            // A code above the chosen resolution keeps the output high.
            next_s.pwm_q[p] = (({s.count[h], s.count[l]} & mask) <=
              {s.compare[h], s.compare[l]});
          end
          if (r16[16]) begin
            next_s.irq[l] = 1'b1;
          end
        end
      end else begin
        if (tk.tick[l]) begin
          r8 = step_count({8'h00, s.count[l]}, {8'h00, s.compare[l]}, `QCP_MASK_8,
            up_l, !pwm && !cap);
          next_s.count[l] = r8[7:0];
          if (pwm) begin
            next_s.pwm_q[p] = (s.count[l] <= s.compare[l]);
          end
          if (r8[16]) begin
            next_s.irq[l] = 1'b1;
          end
        end
        if (tk.tick[h]) begin
          r8 = step_count({8'h00, s.count[h]}, {8'h00, s.compare[h]}, `QCP_MASK_8,
            up_h, !cap);
          next_s.count[h] = r8[7:0];
          if (r8[16]) begin
            next_s.irq[h] = 1'b1;
          end
        end
      end
      if (!pwm) begin
        next_s.pwm_q[p] = 1'b0;
      end
    end

    // Capture latches both A and B and reports on both lines.
    if (capture_on && cap_event) begin
      next_s.shadow[0] = s.count[0];
      next_s.shadow[1] = s.count[1];
      next_s.irq[0] = 1'b1;
      next_s.irq[1] = 1'b1;
    end

    // ----------------------------------------
    // Register writes.
    // ----------------------------------------
    // A write lands after counting, so it wins over a tick in the same cycle.
    if (WR_STB) begin
      case (ADDR)
        `QCP_OFS_COUNT_A, `QCP_OFS_COUNT_B, `QCP_OFS_COUNT_C, `QCP_OFS_COUNT_D: begin
          l = int'(ADDR);
          p_sel_write(l);
        end
        `QCP_OFS_CLK_SEL: begin
          next_s.clk_sel = WR_DATA;
        end
        `QCP_OFS_CONFIG1: begin
          next_s.config1 = WR_DATA;
        end
        `QCP_OFS_CONFIG2: begin
          next_s.config2 = WR_DATA;
        end
        `QCP_OFS_RUN: begin
          next_s.run = WR_DATA;
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------
    // Register reads.
    // ----------------------------------------
    if (RD_STB) begin
      case (ADDR)
        `QCP_OFS_COUNT_A: next_s.rdata = capture_on ? s.shadow[0] : s.count[0];
        `QCP_OFS_COUNT_B: next_s.rdata = capture_on ? s.shadow[1] : s.count[1];
        `QCP_OFS_COUNT_C: next_s.rdata = s.count[2];
        `QCP_OFS_COUNT_D: next_s.rdata = s.count[3];
        `QCP_OFS_CLK_SEL: next_s.rdata = s.clk_sel;
        `QCP_OFS_CONFIG1: next_s.rdata = s.config1;
        `QCP_OFS_CONFIG2: next_s.rdata = s.config2;
        `QCP_OFS_RUN: next_s.rdata = s.run;
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  // Write to a count location: compare always, count only in counter mode.
  // Written as a void function on next_s so the decode above stays readable.
  function automatic void p_sel_write(input int c);
    int pp;
    logic ch;
    logic md;
    logic up;
    pp = c / 2;
    ch = s.config1[`QCP_CFG1_CHAIN_LOW + pp];
    up = ch ? s.config1[`QCP_CFG1_DIR_BASE + 2 * pp] : s.config1[`QCP_CFG1_DIR_BASE + c];
    // Chained PWM covers both bytes; unchained PWM covers only the low counter.
    md = !(pp == 0 && capture_on) && !(s.config1[`QCP_CFG1_PWM0 + pp] && (ch || c % 2 == 0));
    next_s.compare[c] = WR_DATA;
    if (md) begin
      next_s.count[c] = up ? 8'h00 : WR_DATA;
    end
  endfunction

  // ----------------------------------------
  // State register.
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from the state.
  // ----------------------------------------
  assign RD_DATA = s.rdata;
  assign IRQ_A = s.irq[0];
  assign IRQ_B = s.irq[1];
  assign IRQ_C = s.irq[2];
  assign IRQ_D = s.irq[3];
  assign PWM_OUT0 = s.pwm_q[0];
  assign PWM_OUT1 = s.pwm_q[1];
  assign PWM_OE0 = s.config1[`QCP_CFG1_PWM0];
  assign PWM_OE1 = s.config1[`QCP_CFG1_PWM0 + 1];

endmodule

`default_nettype wire

//--- verification/qcp_pin_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Port A pins and internal clock levels.
// ----------------------------------------
module qcp_pin_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] pin_en,
  output logic [3:0] pin_clk,
  output logic int_clk
);
  logic [1:0] ph;

  // A disabled pin stands low, so a stopped counter sees no stray edges.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph <= 2'h0;
      pin_clk <= 4'h0;
      int_clk <= 1'b0;
    end else begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) begin
        int_clk <= ~int_clk;
        pin_clk <= ~pin_clk & pin_en;
      end
    end
  end
endmodule

`default_nettype wire

//--- verification/qcp_counters_sva.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Port checker.
// ----------------------------------------
module qcp_counters_sva (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [7:0] RD_DATA,
  input wire logic IRQ_A,
  input wire logic IRQ_B,
  input wire logic IRQ_C,
  input wire logic IRQ_D,
  input wire logic PWM_OE0,
  input wire logic PWM_OE1
);
  logic [7:4][7:0] sh;
  logic [7:0] cfg1;
  logic [1:0] cap;
  logic [3:0] run;

  assign cfg1 = sh[5];
  assign cap = sh[6][5:4];
  assign run = sh[7][3:0];

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sh <= '0;
    end else if (WR_STB && ADDR[2]) begin
      sh[ADDR] <= WR_DATA;
    end
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  a_reg_readback: assert property ($past(RD_STB && ADDR[2]) |-> RD_DATA == sh[$past(ADDR)])
    else $error("control register read back wrong");
  a_read_idle: assert property (!$past(RD_STB) |-> RD_DATA == 8'h00)
    else $error("read data outside read slot");
  a_oe_mirror: assert property (cfg1 == $past(cfg1) && cfg1 == $past(cfg1, 2)
    |-> {PWM_OE1, PWM_OE0} == cfg1[1:0])
    else $error("pwm enable does not follow config");
  a_irq_c_pulse: assert property (IRQ_C |=> !IRQ_C)
    else $error("irq c longer than one cycle");
  a_pwm0_quiet: assert property (cfg1[0] && $past(cfg1[0], 3) && cap == 2'h0
    && $past(cap, 3) == 2'h0 |-> !IRQ_A)
    else $error("irq a in pwm mode");
  a_chain_quiet: assert property (cfg1[3] && $past(cfg1[3], 3) |-> !IRQ_D)
    else $error("irq d while c and d chained");
  a_stop_quiet: assert property (IRQ_C |-> run[2] || $past(run[2]) || $past(run[2], 2))
    else $error("irq c while stopped");
  a_b_cause: assert property (IRQ_B |-> cap != 2'h0 || run[1] || $past(run[1], 2))
    else $error("irq b without run or capture");
  a_cap_pair: assert property (cap != 2'h0 && $past(cap, 3) == cap |-> IRQ_A == IRQ_B)
    else $error("capture irqs not paired");
endmodule

`default_nettype wire

//--- verification/qcp_counters_test.sv
`timescale 1ns/100ps
`default_nettype none

`include "qcp_defs.svh"

module qcp_counters_test;
  logic REF_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [2:0] ADDR = 3'h0;
  logic [7:0] WR_DATA = 8'h00;
  logic WR_STB = 1'b0;
  logic RD_STB = 1'b0;
  logic CAPTURE_SIG = 1'b0;
  logic [3:0] pin_en = 4'h0;
  logic [3:0] PIN_CLK;
  logic int_clk;
  logic [7:0] RD_DATA;
  logic IRQ_A, IRQ_B, IRQ_C, IRQ_D, PWM_OUT0, PWM_OUT1, PWM_OE0, PWM_OE1;
  logic [3:0] irqs;
  int failures = 0;
  int tests_run = 0;
  int n;

  assign irqs = {IRQ_D, IRQ_C, IRQ_B, IRQ_A};

  always #2.5 REF_CLK = ~REF_CLK;

  qcp_pin_model pins (.clk(REF_CLK), .rst_b(RST_B), .pin_en(pin_en), .pin_clk(PIN_CLK),
    .int_clk(int_clk));

  qcp_counters dut (.REF_CLK(REF_CLK), .RST_B(RST_B), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .PIN_CLK(PIN_CLK),
    .RC_EXT_CLK(int_clk), .RC_EXT_DIV4_CLK(int_clk), .CLK_32K(int_clk), .CLK_1K(int_clk),
    .CLK_128(int_clk), .CAPTURE_SIG(CAPTURE_SIG), .IRQ_A(IRQ_A), .IRQ_B(IRQ_B),
    .IRQ_C(IRQ_C), .IRQ_D(IRQ_D), .PWM_OUT0(PWM_OUT0), .PWM_OUT1(PWM_OUT1),
    .PWM_OE0(PWM_OE0), .PWM_OE1(PWM_OE1));

  // ----------------------------------------
  // Bus and check tasks.
  // ----------------------------------------
  task automatic test_done;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WR_DATA <= d;
    WR_STB <= 1'b1;
    @(posedge REF_CLK);
    WR_STB <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge REF_CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge REF_CLK);
    RD_STB <= 1'b0;
    #1;
    chk("read data", {8'h00, exp}, {8'h00, RD_DATA});
  endtask

  // The wait is bounded so a silent counter ends as a wrong period.
  task automatic waiti(input int i, output int k);
    k = 0;
    do begin
      @(posedge REF_CLK);
      #1;
      k++;
    end while (irqs[i] !== 1'b1 && k < 3000);
  endtask

  task automatic per(input int i, input int exp);
    waiti(i, n);
    waiti(i, n);
    chk("irq period", exp[15:0], n[15:0]);
  endtask

  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge REF_CLK);
    RST_B <= 1'b1;
    for (int a = 4; a < 8; a++) rd(a[2:0], 8'h00);
    wr(`QCP_OFS_CONFIG1, 8'h10);
    wr(`QCP_OFS_COUNT_A, 8'h02);
    rd(`QCP_OFS_COUNT_A, 8'h00);
    wr(`QCP_OFS_CLK_SEL, 8'h03);
    wr(`QCP_OFS_COUNT_B, 8'h05);
    rd(`QCP_OFS_COUNT_B, 8'h05);
    pin_en <= 4'h2;
    wr(`QCP_OFS_RUN, 8'h01);
    per(0, 24);
    rd(`QCP_OFS_COUNT_A, 8'h00);
    rd(`QCP_OFS_COUNT_B, 8'h05);
    // Repeated reads of the stopped pin-clocked counter B agree, so a majority vote is trivial here.
    rd(`QCP_OFS_COUNT_B, 8'h05);
    rd(`QCP_OFS_COUNT_B, 8'h05);
    wr(`QCP_OFS_RUN, 8'h03);
    per(1, 48);
    wr(`QCP_OFS_RUN, 8'h00);
    wr(`QCP_OFS_RUN, 8'h22);
    per(1, 96);
    // Modes change only with the counters stopped.
    wr(`QCP_OFS_RUN, 8'h00);
    wr(`QCP_OFS_CONFIG1, 8'h00);
    wr(`QCP_OFS_COUNT_A, 8'h07);
    wr(`QCP_OFS_CONFIG1, 8'h01);
    wr(`QCP_OFS_COUNT_A, 8'h80);
    rd(`QCP_OFS_COUNT_A, 8'h07);
    chk("pwm enable", 16'h0001, {15'h0000, PWM_OE0});
    wr(`QCP_OFS_CONFIG1, 8'h00);
    rd(`QCP_OFS_COUNT_A, 8'h07);
    wr(`QCP_OFS_CONFIG1, 8'h01);
    wr(`QCP_OFS_RUN, 8'h01);
    repeat (40) @(posedge REF_CLK);
    #1;
    chk("pwm level", 16'h0001, {15'h0000, PWM_OUT0});
    wr(`QCP_OFS_RUN, 8'h00);
    wr(`QCP_OFS_CONFIG1, 8'h00);
    wr(`QCP_OFS_COUNT_A, 8'h09);
    wr(`QCP_OFS_CONFIG2, 8'h10);
    CAPTURE_SIG <= 1'b1;
    waiti(0, n);
    chk("capture pair", 16'h0001, {15'h0000, IRQ_B});
    rd(`QCP_OFS_COUNT_A, 8'h09);
    wr(`QCP_OFS_CONFIG2, 8'h00);
    CAPTURE_SIG <= 1'b0;
    wr(`QCP_OFS_CONFIG1, 8'h48);
    wr(`QCP_OFS_CLK_SEL, 8'h30);
    wr(`QCP_OFS_COUNT_D, 8'h01);
    wr(`QCP_OFS_COUNT_C, 8'h00);
    wr(`QCP_OFS_RUN, 8'h04);
    per(2, 2056);
    rd(`QCP_OFS_COUNT_D, 8'h00);
    chk("pwm1 idle", 16'h0000, {15'h0000, PWM_OUT1});
    test_done;
  end

  initial begin
    repeat (20000) @(posedge REF_CLK);
    failures++;
    test_done;
  end
endmodule

bind qcp_counters qcp_counters_sva chk_i (.REF_CLK(REF_CLK), .RST_B(RST_B), .ADDR(ADDR),
  .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .IRQ_A(IRQ_A),
  .IRQ_B(IRQ_B), .IRQ_C(IRQ_C), .IRQ_D(IRQ_D), .PWM_OE0(PWM_OE0), .PWM_OE1(PWM_OE1));

`default_nettype wire
